/* File: core/scan_map.svh */
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH

// Register geometry: boundary, identification and instruction
`define BS_LENGTH 80
`define ID_WIDTH 32
`define IR_WIDTH 4

// Capture pattern of the instruction register, two lowest bits 01
`define IR_CAPTURE 4'h1

// Safe values: cell 1, output enable input cell 42, serial data cell 58 set; control cell 25 at 0
`define BS_SAFE 80'h0000_0400_0400_0000_0002

// Cells with an update stage; the observe-only cell 38 has none
`define BS_UPDATE_MASK 80'hFFFF_FFFF_FFBF_FFFF_FFFF

// Cell positions in the boundary register, cell 0 nearest the data output
`define BS_CELL_CTRL 25
`define BS_CELL_ALMOST_FULL 34
`define BS_CELL_FIFO_RST 36
`define BS_CELL_VSYNC_EN 38
`define BS_CELL_MAIN_CLK 39
`define BS_CELL_QUAL_CLK 40
`define BS_CELL_OE_N_IN 42
`define BS_CELL_UPB 44
`define BS_CELL_SDA_OUT 58
`define BS_CELL_SDA_IN 59

`endif

/* File: core/scan_pkg.sv */
package scan_pkg;
  `include "scan_map.svh"

  // Sixteen controller states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SHIFT_DR = 16'h0010, EXIT1_DR = 16'h0020, PAUSE_DR = 16'h0040, EXIT2_DR = 16'h0080,
    UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SHIFT_IR = 16'h0800,
    EXIT1_IR = 16'h1000, PAUSE_IR = 16'h2000, EXIT2_IR = 16'h4000, UPD_IR = 16'h8000
  } tap_state_t;

  // The four instruction codes; any other code acts as bypass
  typedef enum logic [`IR_WIDTH-1:0] {
    INS_EXTEST = 4'h0, INS_SAMPLE = 4'h1, INS_IDCODE = 4'h2, INS_BYPASS = 4'hF
  } instr_t;

  // Levels arriving at the input pins
  typedef struct packed {
    logic verticalSyncEnableN;
    logic pixelOutputEnableN;
    logic mainClockInput;
    logic outputFifoResetN;
    logic sda;
  } pin_in_t;

  // Levels and enables for the driven pins
  typedef struct packed {
    logic qualifiedPixelClock;
    logic fifoAlmostFullFlag;
    logic [7:0] upperPixelBus;
    logic groupEnable;
    logic sdaOut;
    logic sdaEnable;
    logic sdaWeakHigh;
  } drive_t;
endpackage : scan_pkg

/* File: core/sync_two_ff.sv */
`timescale 1ns/1ps
// Two-stage level synchroniser; bits are independent levels
module sync_two_ff #(parameter int WIDTH = 1)
(
  input wire logic clk,
  input wire logic ce,
  input wire logic clear,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1; // Read only by the second stage

  // Both stages hold while the enable and clear are low
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else if (ce)
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : sync_two_ff

/* File: core/tap_fsm.sv */
`timescale 1ns/1ps
// Test port controller state machine
module tap_fsm
  import scan_pkg::*;
(
  input wire logic tck,
  input wire logic trstN,
  input wire logic tms,
  output tap_state_t state
);
  tap_state_t next_state; // Successor for the sampled mode select

  // Test reset forces the reset state at once, whatever the clock does
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
      state <= TAP_RESET;
    else
      state <= next_state;
  end

  // Standard transitions on the mode select level
  always_comb
  begin
    unique case (state)
      TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_state = tms ? SEL_DR : TAP_IDLE;
      SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
      CAP_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: next_state = tms ? UPD_DR : PAUSE_DR;
      PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: next_state = tms ? UPD_DR : SHIFT_DR;
      UPD_DR: next_state = tms ? SEL_DR : TAP_IDLE;
      SEL_IR: next_state = tms ? TAP_RESET : CAP_IR;
      CAP_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: next_state = tms ? UPD_IR : PAUSE_IR;
      PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: next_state = tms ? UPD_IR : SHIFT_IR;
      UPD_IR: next_state = tms ? SEL_DR : TAP_IDLE;
      // Corrupted code falls back to reset
      default: next_state = TAP_RESET;
    endcase
  end
endmodule : tap_fsm

/* File: core/boundary_scan_test_port.sv */
`timescale 1ns/1ps
`include "scan_map.svh"
module boundary_scan_test_port
  import scan_pkg::*;
#(
  parameter logic [`ID_WIDTH-1:0] ID_CODE = 32'h0000_1001 // Arbitrary value
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tck,
  input wire logic trstN,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEnable,
  input pin_in_t pinIn,
  output drive_t pinOut,
  input drive_t coreDrive,
  output pin_in_t coreSense,
  input wire logic [`BS_LENGTH-1:0] otherCapture,
  output logic [`BS_LENGTH-1:0] otherDrive,
  output logic extestActive
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  tap_state_t state; // Controller state
  logic [`IR_WIDTH-1:0] irShift; // Instruction shift stage
  logic [`IR_WIDTH-1:0] irHold; // Active instruction
  logic [`BS_LENGTH-1:0] bsShift; // Boundary shift stages
  logic [`BS_LENGTH-1:0] bsUpdate; // Boundary update stages
  logic [`ID_WIDTH-1:0] idShift; // Identification shift stage
  logic bypassBit; // Single-bit bypass stage
  logic [`BS_LENGTH-1:0] rawCapture; // Parallel capture inputs
  logic [`BS_LENGTH-1:0] capSync; // Capture inputs on test clock
  logic [`BS_LENGTH-1:0] xfer; // Update copy held for the crossing
  logic xferPend; // Update waiting to cross
  logic xferReq; // Request toggle, test clock side
  logic ackSync; // Returned acknowledge on test clock
  logic [1:0] reqSync; // Request and extest level on clk
  logic reqSeen; // Last request taken; doubles as acknowledge
  logic [`BS_LENGTH-1:0] updClk; // Update image on clk
  logic extestTck; // Extest decoded on test clock
  logic boundarySel; // Boundary register is the data path
  instr_t active; // Decoded instruction
  logic next_tdo; // Serial bit for the falling edge

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////////////

  // Any unknown code decodes to bypass
  function automatic instr_t decode(input logic [`IR_WIDTH-1:0] code);
    case (code)
      INS_EXTEST: decode = INS_EXTEST;
      INS_SAMPLE: decode = INS_SAMPLE;
      INS_IDCODE: decode = INS_IDCODE;
      default: decode = INS_BYPASS;
    endcase
  endfunction : decode

  // Shift one bit toward the data output end
  function automatic logic [`BS_LENGTH-1:0] shiftBs(input logic [`BS_LENGTH-1:0] v,
                                                    input logic bitIn);
    shiftBs = {bitIn, v[`BS_LENGTH-1:1]};
  endfunction : shiftBs

  ////////////////////////////////////////////////////////////////////////////
  // Controller
  ////////////////////////////////////////////////////////////////////////////

  tap_fsm u_fsm
  (
    .tck(tck),
    .trstN(trstN),
    .tms(tms),
    .state(state)
  );

  // Decode is purely from the held instruction
  assign active = decode(irHold);
  assign boundarySel = (active == INS_EXTEST) || (active == INS_SAMPLE);
  assign extestTck = (active == INS_EXTEST);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  ////////////////////////////////////////////////////////////////////////////

  // Shift stage loads the fixed pattern, then shifts from TDI
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
      irShift <= `IR_CAPTURE;
    else if (state == CAP_IR)
      irShift <= `IR_CAPTURE;
    else if (state == SHIFT_IR)
      irShift <= {tdi, irShift[`IR_WIDTH-1:1]};
  end

  // Identification is the instruction after test reset or in the reset state; rst leaves it
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
      irHold <= INS_IDCODE;
    else if (state == TAP_RESET)
      irHold <= INS_IDCODE;
    else if (state == UPD_IR)
      irHold <= irShift;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture sources
  ////////////////////////////////////////////////////////////////////////////

  // Named cells override the generic boundary inputs
  always_comb
  begin
    rawCapture = otherCapture;
    rawCapture[`BS_CELL_CTRL] = pinOut.groupEnable;
    rawCapture[`BS_CELL_ALMOST_FULL] = pinOut.fifoAlmostFullFlag;
    rawCapture[`BS_CELL_FIFO_RST] = pinIn.outputFifoResetN;
    rawCapture[`BS_CELL_VSYNC_EN] = pinIn.verticalSyncEnableN;
    rawCapture[`BS_CELL_MAIN_CLK] = pinIn.mainClockInput;
    rawCapture[`BS_CELL_QUAL_CLK] = pinOut.qualifiedPixelClock;
    rawCapture[`BS_CELL_OE_N_IN] = pinIn.pixelOutputEnableN;
    for (int i = 0; i < 8; i++)
      rawCapture[`BS_CELL_UPB + i] = pinOut.upperPixelBus[i];
    rawCapture[`BS_CELL_SDA_OUT] = ~pinOut.sdaEnable;
    rawCapture[`BS_CELL_SDA_IN] = pinIn.sda;
  end

  // Pins and clk logic are foreign to the test clock
  sync_two_ff #(.WIDTH(`BS_LENGTH)) u_capSync
  (
    .clk(tck),
    .ce(1'b1),
    .clear(1'b0),
    .din(rawCapture),
    .dout(capSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data registers
  ////////////////////////////////////////////////////////////////////////////

  // Boundary shift stages; capture happens for both boundary instructions
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
      bsShift <= `BS_SAFE;
    else if (boundarySel && state == CAP_DR)
      bsShift <= capSync;
    else if (boundarySel && state == SHIFT_DR)
      bsShift <= shiftBs(bsShift, tdi);
  end

  // Update stages; the observe-only cell keeps its safe value
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
      bsUpdate <= `BS_SAFE;
    else if (boundarySel && state == UPD_DR)
      bsUpdate <= (bsShift & `BS_UPDATE_MASK) | (`BS_SAFE & ~`BS_UPDATE_MASK);
  end

  // Identification stage loads the fixed code on capture
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
      idShift <= '0;
    else if (active == INS_IDCODE && state == CAP_DR)
      idShift <= ID_CODE;
    else if (active == INS_IDCODE && state == SHIFT_DR)
      idShift <= {tdi, idShift[`ID_WIDTH-1:1]};
  end

  // Bypass captures zero, then passes TDI through one stage
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
      bypassBit <= 1'b0;
    else if (state == CAP_DR)
      bypassBit <= 1'b0;
    else if (state == SHIFT_DR)
      bypassBit <= tdi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output
  ////////////////////////////////////////////////////////////////////////////

  // Pick the stage nearest the output for the selected path
  always_comb
  begin
    next_tdo = bypassBit;
    if (state == SHIFT_IR)
      next_tdo = irShift[0];
    else if (boundarySel)
      next_tdo = bsShift[0];
    else if (active == INS_IDCODE)
      next_tdo = idShift[0];
  end

  // Falling edge keeps a half period of hold for the tester
  always_ff @(negedge tck or negedge trstN)
  begin
    if (!trstN)
    begin
      tdo <= 1'b0;
      tdoEnable <= 1'b0;
    end
    else
    begin
      tdo <= next_tdo;
      tdoEnable <= (state == SHIFT_IR) || (state == SHIFT_DR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing of the update image to clk
  ////////////////////////////////////////////////////////////////////////////

  // Acknowledge returns as a level
  sync_two_ff #(.WIDTH(1)) u_ackSync
  (
    .clk(tck),
    .ce(1'b1),
    .clear(1'b0),
    .din(reqSeen),
    .dout(ackSync)
  );

  // A new update waits while the previous copy is still crossing,
  // so the held word never changes under the clk side
  always_ff @(posedge tck or negedge trstN)
  begin
    if (!trstN)
    begin
      xferPend <= 1'b0;
      xferReq <= 1'b0;
      xfer <= `BS_SAFE;
    end
    else if (xferPend && ackSync == xferReq)
    begin
      xfer <= bsUpdate;
      xferReq <= ~xferReq;
      // Fresh update in this cycle stays pending
      xferPend <= boundarySel && state == UPD_DR;
    end
    else if (boundarySel && state == UPD_DR)
      xferPend <= 1'b1;
  end

  // Request toggle and extest level into clk
  sync_two_ff #(.WIDTH(2)) u_reqSync
  (
    .clk(clk),
    .ce(ce),
    .clear(rst),
    .din({xferReq, extestTck}),
    .dout(reqSync)
  );

  // Take the held word on every request edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reqSeen <= 1'b0;
      updClk <= `BS_SAFE;
    end
    else if (ce && reqSync[1] != reqSeen)
    begin
      reqSeen <= reqSync[1];
      updClk <= xfer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin side on clk
  ////////////////////////////////////////////////////////////////////////////

  // Input pins reach the core only through two stages
  sync_two_ff #(.WIDTH($bits(pin_in_t))) u_pinSync
  (
    .clk(clk),
    .ce(ce),
    .clear(rst),
    .din(pinIn),
    .dout(coreSense)
  );

  // Extest takes the pins from the update image; otherwise the core drives
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinOut <= '0;
      extestActive <= 1'b0;
      otherDrive <= `BS_SAFE;
    end
    else if (ce)
    begin
      extestActive <= reqSync[0];
      otherDrive <= updClk;
      if (reqSync[0])
      begin
        pinOut.qualifiedPixelClock <= updClk[`BS_CELL_QUAL_CLK];
        pinOut.fifoAlmostFullFlag <= updClk[`BS_CELL_ALMOST_FULL];
        pinOut.upperPixelBus <= updClk[`BS_CELL_UPB +: 8];
        // Control cell at 0 floats the whole group
        pinOut.groupEnable <= updClk[`BS_CELL_CTRL];
        // Serial data cell is its own control: 1 releases to a weak high
        pinOut.sdaOut <= 1'b0;
        pinOut.sdaEnable <= ~updClk[`BS_CELL_SDA_OUT];
        pinOut.sdaWeakHigh <= updClk[`BS_CELL_SDA_OUT];
      end
      else
      begin
        // Sample and the rest leave normal behaviour alone
        pinOut <= coreDrive;
        pinOut.sdaWeakHigh <= 1'b0;
      end
    end
  end
endmodule : boundary_scan_test_port

/* File: testbench/boundary_scan_test_port_asserts.sv */
`timescale 1ns/1ps
`include "scan_map.svh"
module boundary_scan_test_port_asserts
  import scan_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tck,
  input wire logic trstN,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdoEnable,
  input pin_in_t pinIn,
  input drive_t pinOut,
  input drive_t coreDrive,
  input pin_in_t coreSense,
  input wire logic [`BS_LENGTH-1:0] otherDrive,
  input wire logic extestActive
);
  // Extest and update image quiet for two edges, so pins have caught up
  sequence steady;
    extestActive && $past(extestActive) && $past(otherDrive) == otherDrive
      && $past(otherDrive, 2) == otherDrive;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_core_pass: assert property (@(posedge clk) disable iff (rst)
    !extestActive && $past(!extestActive) && $past(!extestActive, 2) && !$past(rst)
      && $past(ce)
    |-> pinOut == ($past(coreDrive) & 14'h3FFE))
    else $error("pins differ from core drive");
  a_ext_group: assert property (@(posedge clk) disable iff (rst)
    steady |-> pinOut.groupEnable == otherDrive[25])
    else $error("group enable not from control cell");
  a_ext_flag: assert property (@(posedge clk) disable iff (rst)
    steady |-> pinOut.fifoAlmostFullFlag == otherDrive[34])
    else $error("almost full flag not from its cell");
  a_ext_qualified_pixel_clock: assert property (@(posedge clk) disable iff (rst)
    steady |-> pinOut.qualifiedPixelClock == otherDrive[40])
    else $error("pixel clock not from its cell");
  a_ext_upb: assert property (@(posedge clk) disable iff (rst)
    steady |-> pinOut.upperPixelBus == otherDrive[51:44])
    else $error("upper bus not from its cells");
  a_sda_weak: assert property (@(posedge clk) disable iff (rst)
    steady |-> pinOut.sdaWeakHigh == otherDrive[58] && pinOut.sdaEnable == !otherDrive[58]
      && !pinOut.sdaOut)
    else $error("serial data drive wrong");
  a_sense_sync: assert property (@(posedge clk) disable iff (rst)
    pinIn == $past(pinIn) && pinIn == $past(pinIn, 2) && pinIn == $past(pinIn, 3)
      && !$past(rst) && !$past(rst, 2) && !$past(rst, 3) && $past(ce) && $past(ce, 2)
      |-> coreSense == pinIn)
    else $error("sensed pins lag too long");
  a_trst_quiet: assert property (@(posedge clk) disable iff (rst)
    !trstN |-> !tdoEnable && !tdo)
    else $error("data output active in test reset");
  a_shift_exit: assert property (@(posedge tck) disable iff (!trstN)
    tdoEnable && tms |=> !tdoEnable)
    else $error("output stays on after shift");
  a_shift_hold: assert property (@(posedge tck) disable iff (!trstN)
    tdoEnable && !tms |=> tdoEnable)
    else $error("output drops during shift");

  // Main scenarios reached
  c_extest: cover property (@(posedge clk) $rose(extestActive));
  c_float: cover property (@(posedge clk) extestActive && !pinOut.groupEnable);
  c_shift: cover property (@(posedge tck) $rose(tdoEnable));
endmodule : boundary_scan_test_port_asserts

bind boundary_scan_test_port boundary_scan_test_port_asserts chk (.clk(clk), .rst(rst),
  .tck(tck), .trstN(trstN), .tms(tms), .tdo(tdo), .tdoEnable(tdoEnable), .pinIn(pinIn),
  .pinOut(pinOut), .coreDrive(coreDrive), .coreSense(coreSense), .otherDrive(otherDrive),
  .extestActive(extestActive), .ce(ce));

/* File: testbench/scan_master.sv */
`timescale 1ns/1ps
// Board tester model; test clock only runs inside frames
module scan_master
(
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trstN,
  input wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trstN = 1'b1; // High at start, so the first pulse is a real edge
  end

  // One 6 ns period; data out taken at the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #3 tck = 1'b1;
    o = tdo;
    #3 tck = 1'b0;
  endtask : step

  // Reset pulse, then five high mode edges, ending in idle
  task automatic reset_tap();
    logic o;
    trstN = 1'b0;
    #30 trstN = 1'b1; // Spans at least one core clock edge
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : reset_tap

  // Idle to shift, n bits low first, update, then idle edges for the crossing
  task automatic scan(input logic ir, input int n, input logic [79:0] din,
    output logic [79:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    repeat (8) step(1'b0, 1'b0, o);
  endtask : scan
endmodule : scan_master

/* File: testbench/test_boundary_scan_test_port.sv */
`timescale 1ns/1ps
module test_boundary_scan_test_port
  import scan_pkg::*;
();
  localparam logic [31:0] ID_VAL = 32'h0000_5A5B; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // Dropped in one round to freeze the clk side
  logic tck, tms, tdi, trstN, tdo, tdoEnable, extestActive;
  pin_in_t pinIn = '0;
  pin_in_t coreSense;
  drive_t pinOut;
  drive_t coreDrive = '0;
  logic [79:0] otherCapture = '0;
  logic [79:0] otherDrive, got, vec;
  logic [3:0] codes [4] = '{4'h2, 4'hF, 4'h5, 4'hA};
  int seed = 32'h72BA;
  int miscompares = 0;
  int nCompared = 0;
  int cycles = 0;

  boundary_scan_test_port #(.ID_CODE(ID_VAL)) dut (.clk(clk), .rst(rst), .ce(ce), .tck(tck),
    .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEnable(tdoEnable), .pinIn(pinIn),
    .pinOut(pinOut), .coreDrive(coreDrive), .coreSense(coreSense),
    .otherCapture(otherCapture), .otherDrive(otherDrive), .extestActive(extestActive));
  scan_master ctl (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo));

  always #12.5 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk_word(input logic [79:0] g, input logic [79:0] e);
    nCompared++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_pins(input drive_t g, input drive_t e);
    chk_word(80'(g), 80'(e));
  endtask : chk_pins

  // Waits for the extest flag, then lets the pins settle
  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (extestActive !== v && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    #1;
    chk_word(80'(extestActive), 80'(v));
  endtask : wait_flag

  // Held for six clk edges so the pin synchroniser chain sees the new levels
  task automatic new_pins();
    @(posedge clk);
    pinIn <= 5'($random(seed));
    coreDrive <= 14'($random(seed));
    otherCapture <= 80'({$random(seed), $random(seed), $random(seed)});
    repeat (6) @(posedge clk);
    #1;
    chk_word(80'(coreSense), 80'(pinIn));
  endtask : new_pins

  // Captured image: output cells see pin drive, input cells see pins
  function automatic logic [79:0] cap_exp(drive_t p, pin_in_t s, logic [79:0] oth);
    logic [79:0] e;
    e = oth;
    e[25] = p.groupEnable;
    e[34] = p.fifoAlmostFullFlag;
    e[36] = s.outputFifoResetN;
    e[38] = s.verticalSyncEnableN;
    e[39] = s.mainClockInput;
    e[40] = p.qualifiedPixelClock;
    e[42] = s.pixelOutputEnableN;
    e[51:44] = p.upperPixelBus;
    e[58] = !p.sdaEnable;
    e[59] = s.sda;
    return e;
  endfunction : cap_exp

  // Pin drive commanded by an update image
  function automatic drive_t ext_exp(logic [79:0] v);
    drive_t d;
    d = '0;
    d.groupEnable = v[25];
    d.fifoAlmostFullFlag = v[34];
    d.qualifiedPixelClock = v[40];
    d.upperPixelBus = v[51:44];
    d.sdaEnable = !v[58];
    d.sdaWeakHigh = v[58];
    return d;
  endfunction : ext_exp

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ctl.reset_tap();
    ctl.scan(1'b0, 32, 80'h0, got);
    chk_word(got, 80'(ID_VAL));
    chk_word(80'(tdoEnable), 80'h0);
    $display("id test done");
    // Known codes, plus unknown ones that fall back to the one-bit path
    foreach (codes[k])
    begin
      ctl.scan(1'b1, 4, 80'(codes[k]), got);
      chk_word(got, 80'h1);
      ctl.scan(1'b0, 8, 80'hA5, got);
      chk_word(got, (codes[k] == 4'h2) ? 80'(ID_VAL[7:0]) : 80'h4A);
    end
    $display("instruction test done");
    // All ones, all zeros (group floated), then random images
    for (int r = 0; r < 6; r++)
    begin
      vec = (r == 0) ? '1 : (r == 1) ? '0 : 80'({$random(seed), $random(seed), $random(seed)});
      new_pins();
      ctl.scan(1'b1, 4, 80'(INS_SAMPLE), got);
      ctl.scan(1'b0, 80, vec, got);
      chk_word(got, cap_exp(coreDrive & 14'h3FFE, pinIn, otherCapture));
      chk_pins(pinOut, coreDrive & 14'h3FFE);
      ctl.scan(1'b1, 4, 80'(INS_EXTEST), got);
      wait_flag(1'b1);
      chk_pins(pinOut, ext_exp(vec));
      chk_word(otherDrive, vec & ~(80'h1 << 38));
      @(posedge clk);
      ce <= (r != 2); // Round 2 freezes the clk side during the update
      ctl.scan(1'b0, 80, ~vec, got);
      chk_word(got, cap_exp(ext_exp(vec), pinIn, otherCapture));
      repeat (8) @(posedge clk);
      if (r == 2)
      begin
        chk_pins(pinOut, ext_exp(vec));
        ce <= 1'b1;
        repeat (8) @(posedge clk);
      end
      chk_pins(pinOut, ext_exp(~vec));
      ctl.reset_tap();
      wait_flag(1'b0);
      chk_pins(pinOut, coreDrive & 14'h3FFE);
    end
    $display("scan rounds done");
    close_out();
  end
endmodule : test_boundary_scan_test_port
